//--- core/esr_pkg.sv
// Package with constants and types for the exception state register block.
package esr_pkg;

	// Coprocessor register numbers used by register moves.
	localparam logic [4:0] ESR_REG_STATUS = 5'h0C;
	localparam logic [4:0] ESR_REG_CAUSE = 5'h0D;
	localparam logic [4:0] ESR_REG_RETADDR = 5'h0E;
	localparam logic [4:0] ESR_REG_IDENT = 5'h0F;

	// Status field positions.
	localparam int ESR_ST_IE = 0;
	localparam int ESR_ST_EXL = 1;
	localparam int ESR_ST_ERL = 2;

	// Cause field positions.
	localparam int ESR_CA_BD = 31;
	localparam int ESR_CA_CE_HI = 29;
	localparam int ESR_CA_CE_LO = 28;
	localparam int ESR_CA_IV = 23;
	localparam int ESR_CA_WP = 22;
	localparam int ESR_CA_HW_HI = 15;
	localparam int ESR_CA_HW_LO = 10;
	localparam int ESR_CA_SW_HI = 9;
	localparam int ESR_CA_SW_LO = 8;
	localparam int ESR_CA_EXC_HI = 6;
	localparam int ESR_CA_EXC_LO = 2;

	// Identity field positions.
	localparam int ESR_ID_OPT_LO = 24;
	localparam int ESR_ID_MAKER_LO = 16;
	localparam int ESR_ID_TYPE_LO = 8;
	localparam int ESR_ID_REV_LO = 0;

	// Reset values.
	localparam logic [31:0] ESR_CAUSE_RESET = 32'h0000_0000;
	localparam logic [63:0] ESR_RETADDR_RESET = 64'h0000_0000_0000_0000;
	localparam logic [2:0] ESR_STATUS_RESET = 3'h4;

	// Vector offsets.
	localparam logic [11:0] ESR_VEC_REFILL = 12'h000;
	localparam logic [11:0] ESR_VEC_XREFILL = 12'h080;
	localparam logic [11:0] ESR_VEC_GENERAL = 12'h180;
	localparam logic [11:0] ESR_VEC_SPECIAL_INT = 12'h200;
	localparam logic [11:0] ESR_VEC_CACHE_ERR = 12'h100;
	localparam logic [11:0] ESR_VEC_RESET = 12'h000;

	// Exception cause codes.
	typedef enum logic [4:0] {
		ESR_EXC_INT = 5'h00,
		ESR_EXC_MOD = 5'h01,
		ESR_EXC_TLBL = 5'h02,
		ESR_EXC_TLBS = 5'h03,
		ESR_EXC_ADEL = 5'h04,
		ESR_EXC_ADES = 5'h05,
		ESR_EXC_IBE = 5'h06,
		ESR_EXC_DBE = 5'h07,
		ESR_EXC_SYS = 5'h08,
		ESR_EXC_BP = 5'h09,
		ESR_EXC_RI = 5'h0A,
		ESR_EXC_CPU = 5'h0B,
		ESR_EXC_OV = 5'h0C,
		ESR_EXC_TR = 5'h0D,
		ESR_EXC_FPE = 5'h0F,
		ESR_EXC_IMPL0 = 5'h10,
		ESR_EXC_IMPL1 = 5'h11,
		ESR_EXC_COP2 = 5'h12,
		ESR_EXC_WATCH = 5'h17,
		ESR_EXC_MACHINE_CHECK_FAULT = 5'h18,
		ESR_EXC_CACHE = 5'h1E
	} esr_code_t;

	// Exception classes presented by the pipeline.
	typedef enum logic [2:0] {
		ESR_KIND_NORMAL = 3'h0,
		ESR_KIND_REFILL = 3'h1,
		ESR_KIND_XREFILL = 3'h2,
		ESR_KIND_RESET = 3'h3,
		ESR_KIND_SOFT_RESET = 3'h4,
		ESR_KIND_NMI = 3'h5,
		ESR_KIND_CACHE_ERR = 3'h6
	} esr_kind_t;

	// Entry sequencer states.
	typedef enum logic [2:0] {
		ESR_S_RUN = 3'b001,
		ESR_S_ENTER = 3'b010,
		ESR_S_HANDLER = 3'b100
	} esr_state_t;

endpackage : esr_pkg

//--- core/esr_entry_if.sv
// Interface carrying one exception entry record between block modules.
`timescale 1ns/1ps
interface esr_entry_if;
	import esr_pkg::*;
	logic take;
	esr_kind_t kind;
	esr_code_t code;
	logic in_delay_slot;
	logic [1:0] cop_unit;
	logic [63:0] ret_addr;
	logic debug_mode;
	logic [11:0] vector;
	logic level_set;
	logic error_set;
	logic record_cause;
	modport src (output take, kind, code, in_delay_slot, cop_unit, ret_addr, debug_mode);
	modport dec (input take, kind, code, in_delay_slot, cop_unit, ret_addr, debug_mode,
		output vector, level_set, error_set, record_cause);
	modport use_side (input take, kind, code, in_delay_slot, cop_unit, ret_addr, debug_mode,
		vector, level_set, error_set, record_cause);
endinterface : esr_entry_if

//--- core/esr_sync2.sv
// Two-stage synchroniser for a bundle of asynchronous level inputs.
`timescale 1ns/1ps
module esr_sync2 #(
	parameter int WIDTH = 6
) (
	// Clock and reset.
	input wire logic clk,
	input wire logic rst,
	// Data.
	input wire logic [WIDTH-1:0] din,
	output logic [WIDTH-1:0] dout
);
	logic [WIDTH-1:0] meta_r;

	// First stage feeds only the second stage.
	always_ff @(posedge clk) begin
		if (rst) begin
			meta_r <= '0;
			dout <= '0;
		end else begin
			meta_r <= din;
			dout <= meta_r;
		end
	end
endmodule : esr_sync2

//--- core/esr_vector_decode.sv
// Decoder choosing vector offset and level effects for an exception entry.
`timescale 1ns/1ps
module esr_vector_decode
	import esr_pkg::*;
(
	// Entry record, current exception level and interrupt vector bit.
	esr_entry_if.dec ent,
	input wire logic exception_level_flag,
	input wire logic iv
);
	// Decide vector, which level bit to set, and whether cause is recorded.
	always_comb begin
		ent.vector = ESR_VEC_GENERAL;
		ent.level_set = 1'b0;
		ent.error_set = 1'b0;
		ent.record_cause = 1'b0;
		case (ent.kind)
			ESR_KIND_RESET, ESR_KIND_SOFT_RESET, ESR_KIND_NMI: begin
				ent.vector = ESR_VEC_RESET;
				ent.error_set = 1'b1; // [RULE23]
			end
			ESR_KIND_CACHE_ERR: begin
				ent.vector = ESR_VEC_CACHE_ERR;
				ent.error_set = 1'b1; // [RULE23]
				ent.record_cause = ent.debug_mode; // [RULE15]
			end
			ESR_KIND_REFILL: begin
				ent.vector = exception_level_flag ? ESR_VEC_GENERAL : ESR_VEC_REFILL; // [RULE3]
				ent.level_set = 1'b1; // [RULE1]
				ent.record_cause = 1'b1;
			end
			ESR_KIND_XREFILL: begin
				ent.vector = exception_level_flag ? ESR_VEC_GENERAL : ESR_VEC_XREFILL; // [RULE3]
				ent.level_set = 1'b1; // [RULE1]
				ent.record_cause = 1'b1;
			end
			default: begin
				// Interrupts go to the special vector when selected.
				if (ent.code == ESR_EXC_INT && iv)
					ent.vector = ESR_VEC_SPECIAL_INT; // [RULE8]
				else
					ent.vector = ESR_VEC_GENERAL; // [RULE8]
				ent.level_set = 1'b1; // [RULE1]
				ent.record_cause = 1'b1;
			end
		endcase
	end
endmodule : esr_vector_decode

//--- core/esr_top.sv
// Exception state registers: level bits, cause, return address and identity.
// Notes on behaviour
// [RULE1] Non-reset-class exceptions set the exception level.
// [RULE2] Exception level forces kernel mode, blocks interrupts.
// [RULE3] Refills use general vector while level set.
// [RULE4] Nested exception keeps return address and slot flag.
// [RULE5] Status bit 0 is master interrupt enable.
// [RULE6] Cause bit 31 records delay-slot state.
// [RULE7] Cause 29:28 load coprocessor number each exception; reset, soft reset, NMI and cache error outside debug leave them.
// [RULE8] Cause bit 23 picks 0x180 or 0x200.
// [RULE9] Watch under raised level sets deferred bit.
// [RULE10] Deferred watch bit refuses software zero-to-one writes.
// [RULE11] Cause 15:10 show pending hardware interrupts.
// [RULE12] Cause 9:8 are software interrupt requests.
// [RULE13] Cause 6:2 hold the exception code.
// [RULE14] Further codes: trap, float, coprocessor, watch, check.
// [RULE15] Cache error records code only in debug.
// [RULE16] Reserved cause bits read zero, writes ignored.
// [RULE17] Precise exception saves faulting or branch address.
// [RULE18] Imprecise exception saves resume address.
// [RULE19] Return address is 64 writable bits.
// [RULE20] Identity is read-only preset, four byte fields.
// [RULE21] Unimplemented revision or options read zero.
// [RULE22] Software treats zero maker as older architecture.
// [RULE23] Reset-class exceptions set the error level.
// [RULE24] All entry state updates in one cycle.
`timescale 1ns/1ps
module esr_top
	import esr_pkg::*;
#(
	parameter logic [7:0] COMPANY_OPTIONS = 8'h00,
	parameter logic [7:0] MAKER_IDENTIFIER = 8'h5A, // Arbitrary value.
	parameter logic [7:0] PROCESSOR_TYPE = 8'h3C, // Arbitrary value.
	parameter logic [7:0] REVISION = 8'h00,
	parameter bit WATCH_PRESENT = 1'b1,
	parameter int HW_IRQS = 6
) (
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RST,
	// Exception entry from the pipeline.
	input wire logic EXC_TAKE,
	input wire esr_kind_t EXC_KIND,
	input wire esr_code_t EXC_CODE,
	input wire logic EXC_IN_DELAY_SLOT,
	input wire logic EXC_PRECISE,
	input wire logic [1:0] EXC_COP_UNIT,
	input wire logic [63:0] EXC_FAULT_PC,
	input wire logic [63:0] EXC_BRANCH_PC,
	input wire logic [63:0] EXC_RESUME_PC,
	input wire logic EXC_DEBUG_MODE,
	// Exception return and watch match.
	input wire logic ERET,
	input wire logic WATCH_MATCH,
	// Interrupt pins from outside the clock domain.
	input wire logic [HW_IRQS-1:0] HW_INT,
	// Register move port.
	input wire logic REG_WRITE,
	input wire logic [4:0] REG_NUM,
	input wire logic [63:0] REG_WDATA,
	output logic [63:0] REG_RDATA,
	// Status toward the pipeline.
	output logic [11:0] VECTOR_OFFSET,
	output logic KERNEL_FORCED,
	output logic INT_REQUEST,
	output logic WATCH_EXC_REQUEST,
	output logic [2:0] STATUS_LEVELS
);
	logic exl_r;
	logic erl_r;
	logic ie_r;
	logic bd_r;
	logic [1:0] ce_r;
	logic iv_r;
	logic wp_r;
	logic [1:0] sw_r;
	logic [4:0] code_r;
	logic [63:0] epc_r;
	logic [HW_IRQS-1:0] hw_sync;
	logic [31:0] cause_view;
	logic [31:0] ident;
	logic [63:0] rdata_nxt;
	logic wr_status;
	logic wr_cause;
	logic wr_epc;
	logic int_nxt;
	logic [63:0] epc_nxt;
	esr_state_t state_r;

	esr_entry_if ent ();

	// Pipeline drives the entry record straight in.
	assign ent.take = EXC_TAKE;
	assign ent.kind = EXC_KIND;
	assign ent.code = EXC_CODE;
	assign ent.in_delay_slot = EXC_IN_DELAY_SLOT;
	assign ent.cop_unit = EXC_COP_UNIT;
	assign ent.ret_addr = epc_nxt;
	assign ent.debug_mode = EXC_DEBUG_MODE;

	// Return address source: resume point, branch or faulting instruction.
	always_comb begin
		if (!EXC_PRECISE)
			epc_nxt = EXC_RESUME_PC; // [RULE18]
		else if (EXC_IN_DELAY_SLOT)
			epc_nxt = EXC_BRANCH_PC; // [RULE17]
		else
			epc_nxt = EXC_FAULT_PC; // [RULE17]
	end

	esr_vector_decode u_dec (
		.ent(ent.dec),
		.exception_level_flag(exl_r),
		.iv(iv_r)
	);

	esr_sync2 #(.WIDTH(HW_IRQS)) u_sync (
		.clk(CLOCK),
		.rst(RST),
		.din(HW_INT),
		.dout(hw_sync)
	);

	assign wr_status = REG_WRITE && (REG_NUM == ESR_REG_STATUS);
	assign wr_cause = REG_WRITE && (REG_NUM == ESR_REG_CAUSE);
	assign wr_epc = REG_WRITE && (REG_NUM == ESR_REG_RETADDR);

	// Entry sequencer tracks running, entering and inside a handler.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			state_r <= ESR_S_RUN;
		end else begin
			case (state_r)
				ESR_S_RUN: if (EXC_TAKE) state_r <= ESR_S_ENTER;
				ESR_S_ENTER: state_r <= ESR_S_HANDLER;
				ESR_S_HANDLER: if (ERET && !EXC_TAKE) state_r <= ESR_S_RUN;
				default: state_r <= ESR_S_RUN;
			endcase
		end
	end

	// Level bits and master enable; hardware entry wins over a software write.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			ie_r <= ESR_STATUS_RESET[ESR_ST_IE];
			exl_r <= ESR_STATUS_RESET[ESR_ST_EXL];
			erl_r <= ESR_STATUS_RESET[ESR_ST_ERL];
		end else begin
			if (wr_status) begin
				ie_r <= REG_WDATA[ESR_ST_IE]; // [RULE5]
				exl_r <= REG_WDATA[ESR_ST_EXL];
				erl_r <= REG_WDATA[ESR_ST_ERL];
			end else if (ERET) begin
				// Return clears the error level first, else the exception level.
				if (erl_r)
					erl_r <= 1'b0;
				else
					exl_r <= 1'b0;
			end
			if (EXC_TAKE && ent.level_set)
				exl_r <= 1'b1; // [RULE1] [RULE24]
			if (EXC_TAKE && ent.error_set)
				erl_r <= 1'b1; // [RULE23]
		end
	end

	// Entry record: code, slot flag, coprocessor number, return address.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			bd_r <= ESR_CAUSE_RESET[ESR_CA_BD];
			ce_r <= ESR_CAUSE_RESET[ESR_CA_CE_HI:ESR_CA_CE_LO];
			code_r <= ESR_CAUSE_RESET[ESR_CA_EXC_HI:ESR_CA_EXC_LO];
			epc_r <= ESR_RETADDR_RESET;
		end else begin
			if (wr_epc)
				epc_r <= REG_WDATA; // [RULE19]
			if (EXC_TAKE && ent.record_cause) begin
				code_r <= EXC_CODE; // [RULE13] [RULE14] [RULE15] [RULE24]
				ce_r <= EXC_COP_UNIT; // [RULE7]
				if (!exl_r && ent.level_set) begin
					bd_r <= EXC_IN_DELAY_SLOT; // [RULE6] [RULE4]
					epc_r <= ent.ret_addr; // [RULE17] [RULE18] [RULE4] [RULE24]
				end
			end
		end
	end

	// Software-writable cause fields; deferred watch set beats any clear.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			iv_r <= ESR_CAUSE_RESET[ESR_CA_IV];
			sw_r <= ESR_CAUSE_RESET[ESR_CA_SW_HI:ESR_CA_SW_LO];
			wp_r <= ESR_CAUSE_RESET[ESR_CA_WP];
		end else begin
			if (wr_cause) begin
				iv_r <= REG_WDATA[ESR_CA_IV]; // [RULE8]
				sw_r <= REG_WDATA[ESR_CA_SW_HI:ESR_CA_SW_LO]; // [RULE12]
				if (!REG_WDATA[ESR_CA_WP])
					wp_r <= 1'b0; // [RULE10]
			end
			if (WATCH_PRESENT && WATCH_MATCH && (exl_r || erl_r))
				wp_r <= 1'b1; // [RULE9]
			if (!WATCH_PRESENT)
				wp_r <= 1'b0; // [RULE10]
		end
	end

	// Cause as seen by software; reserved bits are zero.
	always_comb begin
		cause_view = 32'h0000_0000; // [RULE16]
		cause_view[ESR_CA_BD] = bd_r;
		cause_view[ESR_CA_CE_HI:ESR_CA_CE_LO] = ce_r;
		cause_view[ESR_CA_IV] = iv_r;
		cause_view[ESR_CA_WP] = wp_r;
		cause_view[ESR_CA_HW_HI:ESR_CA_HW_LO] = hw_sync; // [RULE11]
		cause_view[ESR_CA_SW_HI:ESR_CA_SW_LO] = sw_r;
		cause_view[ESR_CA_EXC_HI:ESR_CA_EXC_LO] = code_r;
	end

	// Preset identity word.
	assign ident = {COMPANY_OPTIONS, MAKER_IDENTIFIER, PROCESSOR_TYPE, REVISION}; // [RULE20] [RULE21]

	// Read multiplexer; unknown register numbers read zero.
	always_comb begin
		case (REG_NUM)
			ESR_REG_STATUS: rdata_nxt = {61'h0, erl_r, exl_r, ie_r};
			ESR_REG_CAUSE: rdata_nxt = {32'h0000_0000, cause_view};
			ESR_REG_RETADDR: rdata_nxt = epc_r;
			ESR_REG_IDENT: rdata_nxt = {32'h0000_0000, ident};
			default: rdata_nxt = 64'h0000_0000_0000_0000;
		endcase
	end

	// Interrupt request needs enable, both levels clear, and a pending source.
	assign int_nxt = ie_r && !exl_r && !erl_r && (|{hw_sync, sw_r}); // [RULE2] [RULE5] [RULE12]

	// Registered outputs.
	always_ff @(posedge CLOCK) begin
		if (RST) begin
			REG_RDATA <= 64'h0000_0000_0000_0000;
			VECTOR_OFFSET <= ESR_VEC_RESET;
			KERNEL_FORCED <= 1'b1;
			INT_REQUEST <= 1'b0;
			WATCH_EXC_REQUEST <= 1'b0;
			STATUS_LEVELS <= ESR_STATUS_RESET;
		end else begin
			REG_RDATA <= rdata_nxt;
			if (EXC_TAKE)
				VECTOR_OFFSET <= ent.vector; // [RULE3] [RULE8]
			KERNEL_FORCED <= exl_r || erl_r; // [RULE2] [RULE23]
			INT_REQUEST <= int_nxt;
			WATCH_EXC_REQUEST <= wp_r && !exl_r && !erl_r; // [RULE9]
			STATUS_LEVELS <= {erl_r, exl_r, ie_r};
		end
	end

endmodule : esr_top

//--- sim/esr_assertions.sv
// Concurrent checks on the exception state register block ports.
`timescale 1ns/1ps
module esr_assertions
	import esr_pkg::*;
#(
	parameter logic [7:0] COMPANY_OPTIONS = 8'h00,
	parameter logic [7:0] MAKER_IDENTIFIER = 8'h5A, // Arbitrary value.
	parameter logic [7:0] PROCESSOR_TYPE = 8'h3C, // Arbitrary value.
	parameter logic [7:0] REVISION = 8'h00,
	parameter int HW_IRQS = 6
) (
	// Clock and reset.
	input wire logic CLOCK,
	input wire logic RST,
	// Stimulus seen at the block.
	input wire logic EXC_TAKE,
	input wire esr_kind_t EXC_KIND,
	input wire logic ERET,
	input wire logic REG_WRITE,
	input wire logic [4:0] REG_NUM,
	input wire logic [HW_IRQS-1:0] HW_INT,
	// Outputs under check.
	input wire logic [63:0] REG_RDATA,
	input wire logic [11:0] VECTOR_OFFSET,
	input wire logic KERNEL_FORCED,
	input wire logic INT_REQUEST,
	input wire logic WATCH_EXC_REQUEST,
	input wire logic [2:0] STATUS_LEVELS
);
	// All checks run on the core clock and rest while reset is high.
	default clocking cb @(posedge CLOCK); endclocking
	default disable iff (RST);

	// Entry effects show on the level bits two edges after the take and on the vector one edge after.
	a_exc_level_set: assert property (EXC_TAKE && EXC_KIND inside {ESR_KIND_NORMAL, ESR_KIND_REFILL,
		ESR_KIND_XREFILL} |-> ##2 STATUS_LEVELS[ESR_ST_EXL]) else $error("exception level not raised");
	a_err_level_set: assert property (EXC_TAKE && EXC_KIND inside {ESR_KIND_RESET, ESR_KIND_SOFT_RESET,
		ESR_KIND_NMI, ESR_KIND_CACHE_ERR} |-> ##2 STATUS_LEVELS[ESR_ST_ERL]) else $error("error level not raised");
	a_refill_general: assert property (EXC_TAKE && EXC_KIND inside {ESR_KIND_REFILL, ESR_KIND_XREFILL}
		&& STATUS_LEVELS[ESR_ST_EXL] && !$past(EXC_TAKE) && !$past(ERET) && !$past(REG_WRITE) && !$past(RST)
		|-> ##2 VECTOR_OFFSET == ESR_VEC_GENERAL) else $error("nested refill took wrong vector");

	// Level bits force kernel mode and block interrupts and watch traps.
	a_kernel_mode: assert property (KERNEL_FORCED == (STATUS_LEVELS[ESR_ST_EXL] || STATUS_LEVELS[ESR_ST_ERL]))
		else $error("kernel mode does not follow levels");
	a_int_gated: assert property (INT_REQUEST |-> STATUS_LEVELS == 3'h1)
		else $error("interrupt request while blocked");
	a_watch_deferred: assert property (WATCH_EXC_REQUEST |-> STATUS_LEVELS[2:1] == 2'h0)
		else $error("watch trap while a level is set");

	// Register reads return fixed fields and the pending hardware bits one cycle after the number.
	a_ident_read: assert property (REG_NUM == ESR_REG_IDENT |=> REG_RDATA == {32'h0000_0000,
		COMPANY_OPTIONS, MAKER_IDENTIFIER, PROCESSOR_TYPE, REVISION}) else $error("identity read wrong");
	a_cause_zeros: assert property (REG_NUM == ESR_REG_CAUSE |=>
		(REG_RDATA & 64'hFFFF_FFFF_4F3F_0083) == 64'h0) else $error("reserved cause bits not zero");
	a_hw_pending: assert property (REG_NUM == ESR_REG_CAUSE && $stable(HW_INT) && HW_INT == $past(HW_INT, 2)
		&& HW_INT == $past(HW_INT, 3) |=> REG_RDATA[ESR_CA_HW_HI:ESR_CA_HW_LO] == $past(HW_INT))
		else $error("pending hardware bits wrong");
endmodule : esr_assertions

bind esr_top esr_assertions #(.COMPANY_OPTIONS(COMPANY_OPTIONS), .MAKER_IDENTIFIER(MAKER_IDENTIFIER),
	.PROCESSOR_TYPE(PROCESSOR_TYPE), .REVISION(REVISION), .HW_IRQS(HW_IRQS)) u_esr_assertions (
	.CLOCK(CLOCK), .RST(RST), .EXC_TAKE(EXC_TAKE), .EXC_KIND(EXC_KIND), .ERET(ERET), .REG_WRITE(REG_WRITE),
	.REG_NUM(REG_NUM), .HW_INT(HW_INT), .REG_RDATA(REG_RDATA), .VECTOR_OFFSET(VECTOR_OFFSET),
	.KERNEL_FORCED(KERNEL_FORCED), .INT_REQUEST(INT_REQUEST), .WATCH_EXC_REQUEST(WATCH_EXC_REQUEST),
	.STATUS_LEVELS(STATUS_LEVELS));

//--- sim/esr_pipe_model.sv
// Model of the pipeline presenting exception entries, returns and watch matches.
`timescale 1ns/1ps
module esr_pipe_model
	import esr_pkg::*;
(
	// Clock.
	input wire logic clk,
	// Entry record and pulses toward the block.
	output logic take = 1'b0,
	output esr_kind_t kind = ESR_KIND_NORMAL,
	output esr_code_t code = ESR_EXC_INT,
	output logic slot = 1'b0,
	output logic precise = 1'b1,
	output logic [1:0] cop = 2'h0,
	output logic dbg = 1'b0,
	output logic [63:0] fault_pc = 64'h0,
	output logic [63:0] branch_pc = 64'h0,
	output logic [63:0] resume_pc = 64'h0,
	output logic eret = 1'b0,
	output logic watch = 1'b0
);
	// Present one entry for one cycle, then invert the addresses so stale values never match.
	task automatic enter(input esr_kind_t k, input esr_code_t c, input logic s, input logic p,
		input logic [1:0] u, input logic d, input logic [63:0] pc);
		@(posedge clk);
		take <= 1'b1;
		kind <= k;
		code <= c;
		slot <= s;
		precise <= p;
		cop <= u;
		dbg <= d;
		fault_pc <= pc;
		branch_pc <= pc - 64'h4;
		resume_pc <= pc + 64'h4;
		@(posedge clk);
		take <= 1'b0;
		fault_pc <= ~fault_pc;
		branch_pc <= ~branch_pc;
		resume_pc <= ~resume_pc;
	endtask : enter

	// Single-cycle return pulse.
	task automatic pulse_eret;
		@(posedge clk);
		eret <= 1'b1;
		@(posedge clk);
		eret <= 1'b0;
	endtask : pulse_eret

	// Single-cycle watch match pulse.
	task automatic pulse_watch;
		@(posedge clk);
		watch <= 1'b1;
		@(posedge clk);
		watch <= 1'b0;
	endtask : pulse_watch
endmodule : esr_pipe_model

//--- sim/esr_top_tb.sv
// Self-checking testbench for the exception state register block.
`timescale 1ns/1ps
module esr_top_tb;
	import esr_pkg::*;
	localparam logic [7:0] MAKER = 8'h6B; // Arbitrary value.
	localparam logic [7:0] PTYPE = 8'h2D; // Arbitrary value.
	localparam logic [63:0] IDENT = {32'h0, 8'h00, MAKER, PTYPE, 8'h00};
	logic CLOCK = 1'b0;
	logic RST = 1'b1;
	logic EXC_TAKE, EXC_IN_DELAY_SLOT, EXC_PRECISE, EXC_DEBUG_MODE, ERET, WATCH_MATCH;
	esr_kind_t EXC_KIND;
	esr_code_t EXC_CODE;
	esr_code_t code;
	logic [1:0] EXC_COP_UNIT;
	logic [63:0] EXC_FAULT_PC, EXC_BRANCH_PC, EXC_RESUME_PC, REG_RDATA;
	logic [63:0] REG_WDATA = 64'h0;
	logic [5:0] HW_INT = 6'h00;
	logic REG_WRITE = 1'b0;
	logic [4:0] REG_NUM = 5'h1F;
	logic [11:0] VECTOR_OFFSET;
	logic KERNEL_FORCED, INT_REQUEST, WATCH_EXC_REQUEST;
	logic [2:0] STATUS_LEVELS;
	int fail_count = 0;
	int n_compared = 0;

	// Core clock at 50 MHz.
	always #10 CLOCK = ~CLOCK;

	// Block under test and the pipeline model beside it.
	esr_top #(.MAKER_IDENTIFIER(MAKER), .PROCESSOR_TYPE(PTYPE)) uut (.CLOCK(CLOCK), .RST(RST),
		.EXC_TAKE(EXC_TAKE), .EXC_KIND(EXC_KIND), .EXC_CODE(EXC_CODE), .EXC_IN_DELAY_SLOT(EXC_IN_DELAY_SLOT),
		.EXC_PRECISE(EXC_PRECISE), .EXC_COP_UNIT(EXC_COP_UNIT), .EXC_FAULT_PC(EXC_FAULT_PC),
		.EXC_BRANCH_PC(EXC_BRANCH_PC), .EXC_RESUME_PC(EXC_RESUME_PC), .EXC_DEBUG_MODE(EXC_DEBUG_MODE),
		.ERET(ERET), .WATCH_MATCH(WATCH_MATCH), .HW_INT(HW_INT), .REG_WRITE(REG_WRITE), .REG_NUM(REG_NUM),
		.REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .VECTOR_OFFSET(VECTOR_OFFSET),
		.KERNEL_FORCED(KERNEL_FORCED), .INT_REQUEST(INT_REQUEST), .WATCH_EXC_REQUEST(WATCH_EXC_REQUEST),
		.STATUS_LEVELS(STATUS_LEVELS));
	esr_pipe_model pm (.clk(CLOCK), .take(EXC_TAKE), .kind(EXC_KIND), .code(EXC_CODE), .slot(EXC_IN_DELAY_SLOT),
		.precise(EXC_PRECISE), .cop(EXC_COP_UNIT), .dbg(EXC_DEBUG_MODE), .fault_pc(EXC_FAULT_PC),
		.branch_pc(EXC_BRANCH_PC), .resume_pc(EXC_RESUME_PC), .eret(ERET), .watch(WATCH_MATCH));

	// Compare one value and count it.
	task automatic chk(input string name, input logic [63:0] exp, input logic [63:0] got);
		n_compared++;
		if (got !== exp) begin
			fail_count++;
			$display("MISMATCH %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	// Register move write, taken at the edge after it is driven.
	task automatic wr(input logic [4:0] num, input logic [63:0] d);
		@(posedge CLOCK);
		REG_WRITE <= 1'b1;
		REG_NUM <= num;
		REG_WDATA <= d;
		@(posedge CLOCK);
		REG_WRITE <= 1'b0;
	endtask : wr

	// Register move read and compare.
	task automatic rd(input string name, input logic [4:0] num, input logic [63:0] exp);
		@(posedge CLOCK);
		REG_NUM <= num;
		repeat (2) @(posedge CLOCK);
		#1 chk(name, exp, REG_RDATA);
	endtask : rd

	// Check the vector one edge after an entry finished.
	task automatic vec(input logic [11:0] exp);
		@(posedge CLOCK);
		#1 chk("vector", 64'(exp), 64'(VECTOR_OFFSET));
	endtask : vec

	// Print counts and the verdict, then stop.
	task automatic give_verdict;
		$display("compared %0d mismatches %0d", n_compared, fail_count);
		if (fail_count == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask : give_verdict

	// Guard against a hang.
	initial begin
		repeat (20000) @(posedge CLOCK);
		fail_count++;
		give_verdict();
	end

	// Main sequence.
	initial begin
		repeat (5) @(posedge CLOCK);
		RST <= 1'b0;
		rd("status", ESR_REG_STATUS, 64'(ESR_STATUS_RESET));
		rd("ident", ESR_REG_IDENT, IDENT);
		rd("unmapped", 5'h03, 64'h0);
		wr(ESR_REG_IDENT, 64'hFFFF_FFFF);
		rd("ident", ESR_REG_IDENT, IDENT);
		wr(ESR_REG_RETADDR, 64'hF0E1_D2C3_B4A5_9687);
		rd("retaddr", ESR_REG_RETADDR, 64'hF0E1_D2C3_B4A5_9687);
		wr(ESR_REG_STATUS, 64'h1);
		rd("status", ESR_REG_STATUS, 64'h1);
		// Precise entry in a delay slot, then a nested refill.
		pm.enter(ESR_KIND_NORMAL, ESR_EXC_OV, 1'b1, 1'b1, 2'h2, 1'b0, 64'h8000_1000);
		vec(ESR_VEC_GENERAL);
		rd("cause", ESR_REG_CAUSE, 64'hA000_0030);
		rd("retaddr", ESR_REG_RETADDR, 64'h8000_0FFC);
		rd("status", ESR_REG_STATUS, 64'h3);
		pm.enter(ESR_KIND_REFILL, ESR_EXC_TLBL, 1'b0, 1'b1, 2'h1, 1'b0, 64'h9000_2000);
		vec(ESR_VEC_GENERAL);
		rd("cause", ESR_REG_CAUSE, 64'h9000_0008);
		rd("retaddr", ESR_REG_RETADDR, 64'h8000_0FFC);
		pm.pulse_eret();
		pm.enter(ESR_KIND_NORMAL, ESR_EXC_DBE, 1'b0, 1'b0, 2'h0, 1'b0, 64'h1_0000_0040);
		rd("cause", ESR_REG_CAUSE, 64'h0000_001C);
		rd("retaddr", ESR_REG_RETADDR, 64'h1_0000_0044);
		pm.pulse_eret();
		// Every code is recorded.
		code = code.first();
		do begin
			pm.enter(ESR_KIND_NORMAL, code, 1'b0, 1'b1, 2'h3, 1'b1, 64'h40);
			rd("code", ESR_REG_CAUSE, 64'h3000_0000 | (64'(code) << 2));
			pm.pulse_eret();
			code = code.next();
		end while (code != code.first());
		// Reset-class entries raise the error level and leave the cause alone.
		for (int k = 3; k < 7; k++) begin
			pm.enter(esr_kind_t'(3'(k)), ESR_EXC_TLBS, 1'b1, 1'b1, 2'h0, 1'b0, 64'h80);
			rd("status", ESR_REG_STATUS, 64'h5);
			rd("cause", ESR_REG_CAUSE, 64'h3000_0078);
			pm.pulse_eret();
		end
		// Writable cause fields, software interrupts and the interrupt vector.
		wr(ESR_REG_CAUSE, 64'hFFFF_FFFF_FFBF_FFFF);
		rd("cause", ESR_REG_CAUSE, 64'h3080_0378);
		#1 chk("intreq", 64'h1, 64'(INT_REQUEST));
		pm.enter(ESR_KIND_NORMAL, ESR_EXC_INT, 1'b0, 1'b0, 2'h0, 1'b0, 64'h100);
		vec(ESR_VEC_SPECIAL_INT);
		chk("intreq", 64'h0, 64'(INT_REQUEST));
		pm.pulse_eret();
		wr(ESR_REG_CAUSE, 64'h0300);
		pm.enter(ESR_KIND_NORMAL, ESR_EXC_INT, 1'b0, 1'b0, 2'h0, 1'b0, 64'h100);
		vec(ESR_VEC_GENERAL);
		pm.pulse_eret();
		wr(ESR_REG_STATUS, 64'h0);
		rd("status", ESR_REG_STATUS, 64'h0);
		#1 chk("intreq", 64'h0, 64'(INT_REQUEST));
		// Hardware interrupt pins reach the pending bits.
		wr(ESR_REG_CAUSE, 64'h0);
		HW_INT <= 6'h21;
		repeat (4) @(posedge CLOCK);
		rd("cause", ESR_REG_CAUSE, 64'h8400);
		HW_INT <= 6'h00;
		// Deferred watch, its trap after return, and software clearing.
		pm.enter(ESR_KIND_NORMAL, ESR_EXC_WATCH, 1'b0, 1'b1, 2'h0, 1'b0, 64'h200);
		pm.pulse_watch();
		rd("cause", ESR_REG_CAUSE, 64'h0040_005C);
		chk("watchreq", 64'h0, 64'(WATCH_EXC_REQUEST));
		pm.pulse_eret();
		repeat (2) @(posedge CLOCK);
		#1 chk("watchreq", 64'h1, 64'(WATCH_EXC_REQUEST));
		wr(ESR_REG_CAUSE, 64'h0);
		rd("cause", ESR_REG_CAUSE, 64'h005C);
		chk("watchreq", 64'h0, 64'(WATCH_EXC_REQUEST));
		wr(ESR_REG_CAUSE, 64'h0040_0000);
		rd("cause", ESR_REG_CAUSE, 64'h005C);
		give_verdict();
	end
endmodule : esr_top_tb
